// ### inc/icd_pkg.sv
package icd_pkg;
   localparam int WORD_W = 24;
   localparam int LIT_W = 23;
   localparam int OPC_LO = 16;
   localparam int OPC_W = 8;
   // Register byte offsets.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_CORE_FLAGS = 8'h04;
   localparam logic [7:0] ADR_DSP_FLAGS = 8'h08;
   localparam logic [7:0] ADR_LAST_WORD = 8'h0C;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // Core flag bit positions: carry, digit carry, negative, overflow, sticky zero.
   localparam int FL_C = 4;
   localparam int FL_DC = 3;
   localparam int FL_N = 2;
   localparam int FL_OV = 1;
   localparam int FL_Z = 0;
   // Dsp flag bit positions.
   localparam int FD_OA = 3;
   localparam int FD_OB = 2;
   localparam int FD_SA = 1;
   localparam int FD_SB = 0;
   // Operand field positions inside the low 16 bits.
   localparam int F_BASE = 12;
   localparam int F_DMODE = 10;
   localparam int F_DREG = 6;
   localparam int F_SMODE = 4;
   localparam int F_SREG = 0;
   localparam int F_DSEL = 15;
   localparam int F_FADDR_W = 13;
   localparam int F_UNSIGNED_LITERAL_TEN = 4;
   localparam int F_BIT_POSITION_FIELD = 12;
   localparam int F_POSREG = 7;
   localparam int F_BBASE = 8;
   localparam int F_ACC = 15;
   localparam int F_AWB = 13;
   localparam int F_MX = 11;
   localparam int F_MY = 9;
   localparam int F_SHREG = 14;
   localparam int F_SLIT6 = 8;
   localparam int F_W2ADR_W = 7;
   localparam logic [OPC_W-1:0] OPC_NOP = 8'h00;
   localparam logic [OPC_W-1:0] OPC_BR_IND = 8'h01;
   localparam logic [OPC_W-1:0] OPC_CALL = 8'h02;
   localparam logic [OPC_W-1:0] OPC_JUMP = 8'h04;
   localparam logic [OPC_W-1:0] OPC_LONG = 8'h05;
   localparam logic [OPC_W-1:0] OPC_RET = 8'h06;
   localparam logic [OPC_W-1:0] OPC_RETI = 8'h07;
   localparam logic [3:0] COND_ALWAYS = 4'hF;
   localparam logic [3:0] SIZE_MASK_LIT_BYTE = 4'h1;
   localparam logic [9:0] UNSIGNED_LITERAL_TEN_BYTE_MAX = 10'h0FF;
   localparam logic [3:0] W13 = 4'hD;
   localparam logic [3:0] MAC_W_BASE = 4'h4;
   localparam logic [1:0] SZ_WORD = 2'h0;
   localparam logic [1:0] SZ_BYTE = 2'h1;
   localparam logic [1:0] SZ_DOUBLE = 2'h2;
   localparam logic [1:0] AWB_NONE = 2'h0;
   localparam logic [1:0] EXTRA_BRANCH = 2'h1;
   localparam logic [1:0] EXTRA_TABLE = 2'h1;
   localparam logic [1:0] EXTRA_RETURN = 2'h2;
   localparam logic [1:0] EXTRA_MOVD = 2'h1;
   typedef enum logic [3:0] {
      CLS_NOP = 4'b0000, CLS_WORKING_REG_ZERO = 4'b0001, CLS_FREG = 4'b0010, CLS_BIT = 4'b0011,
      CLS_LIT = 4'b0100, CLS_MAC = 4'b0101, CLS_DSP = 4'b0110, CLS_BRCOND = 4'b0111,
      CLS_BRIND = 4'b1000, CLS_CALL2 = 4'b1001, CLS_JUMP2 = 4'b1010, CLS_RET = 4'b1011,
      CLS_TABLE = 4'b1100, CLS_SKIP = 4'b1101, CLS_MOVD = 4'b1110, CLS_LONG2 = 4'b1111
   } icd_class_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000, ST_WORD2 = 3'b001, ST_NOPS = 3'b010, ST_SKIPCHK = 3'b011,
      ST_SKIP2 = 3'b100
   } icd_state_t;
endpackage

// ### src/icd_decoder.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
// What this block does
// RULE1: 24-bit word, 8-bit opcode selects type.
// RULE2: Two-word unit; second word top byte zero.
// RULE3: Lone second word executes as no-operation.
// RULE4: One cycle; taken test or jump adds nop.
// RULE5: Branches, tables, returns take two/three cycles.
// RULE6: Skip costs two or three cycles.
// RULE7: Two-word instructions take two cycles.
// RULE8: Register ops: base, modified source, modified destination.
// RULE9: File ops: address plus file/W0 destination.
// RULE10: Bit ops: position from literal or register.
// RULE11: Literal ops: destination encoded only if different.
// RULE12: Multiply-accumulate: accumulator, multiplicands, prefetch, writeback.
// RULE13: Other dsp: accumulator, operand, shift source.
// RULE14: Writeback to W13 or [W13] post-increment two.
// RULE15: Bit field gives positions 0 to 15.
// RULE16: Ten-bit literal: 255 byte, 1023 word.
// RULE17: Program address literal has zero LSB.
// RULE18: Signed ten-bit literal spans -512 to 511.
// RULE19: Keep carry, digit, negative, overflow, sticky zero.
// RULE20: Keep overflow and saturate per accumulator.
// RULE21: Size suffix: byte, word, double, shadow.
// RULE22: Stall issue and insert nop slots.
module icd_decoder import icd_pkg::*; #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 32
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic FETCH_VALID_I,
   input wire logic [WORD_W-1:0] FETCH_WORD_I,
   input wire logic SKIP_TAKEN_I,
   input wire logic DP_RESULT_VALID_I,
   input wire logic [4:0] DP_CORE_FLAGS_I,
   input wire logic [3:0] DP_DSP_FLAGS_I,
   input wire logic [ADDR_W-1:0] BUS_ADDR_I,
   input wire logic [DATA_W-1:0] BUS_WDATA_I,
   input wire logic BUS_WR_I,
   input wire logic BUS_RD_I,
   output logic [DATA_W-1:0] BUS_RDATA_O,
   output logic STALL_O,
   output logic ISSUE_O,
   output logic SECOND_WORD_O,
   output logic NOP_SLOT_O,
   output logic [OPC_W-1:0] OPCODE_O,
   output logic [3:0] CLASS_O,
   output logic [1:0] SIZE_O,
   output logic [3:0] BASE_REG_O,
   output logic [3:0] SRC_REG_O,
   output logic [1:0] SRC_MODE_O,
   output logic [3:0] DST_REG_O,
   output logic [1:0] DST_MODE_O,
   output logic [F_FADDR_W-1:0] FILE_ADDR_O,
   output logic DEST_IS_FILE_O,
   output logic [3:0] BIT_POS_O,
   output logic POS_FROM_REG_O,
   output logic [LIT_W-1:0] LITERAL_O,
   output logic ACC_SEL_O,
   output logic [1:0] AWB_MODE_O,
   output logic [8:0] MAC_PREFETCH_O,
   output logic SHIFT_FROM_REG_O,
   output logic OPERAND_ERR_O,
   output logic [4:0] CORE_FLAGS_O,
   output logic [3:0] DSP_FLAGS_O
);
   function automatic icd_class_t opc_class(input logic [OPC_W-1:0] opc);
      icd_class_t c;
      c = CLS_NOP;
      case (opc[7:4])
         4'h0: begin
            case (opc)
               OPC_BR_IND: c = CLS_BRIND;
               OPC_CALL: c = CLS_CALL2;
               OPC_JUMP: c = CLS_JUMP2;
               OPC_LONG: c = CLS_LONG2;
               OPC_RET, OPC_RETI: c = CLS_RET;
               default: c = CLS_NOP;
            endcase
         end
         4'h3: c = CLS_BRCOND;
         4'h4: c = CLS_WORKING_REG_ZERO;
         4'h5: c = CLS_LIT;
         4'h6: c = CLS_FREG;
         4'h7: c = CLS_BIT;
         4'h8: c = CLS_SKIP;
         4'h9: c = CLS_TABLE;
         4'hA: c = CLS_MOVD;
         4'hB: c = CLS_DSP;
         4'hC, 4'hD, 4'hE, 4'hF: c = CLS_MAC;
         default: c = CLS_NOP;
      endcase
      return c;
   endfunction

   function automatic logic is_two_word(input icd_class_t c);
      return (c == CLS_CALL2) || (c == CLS_JUMP2) || (c == CLS_LONG2);
   endfunction

   logic [1:0] ctrl_ff;
   logic [4:0] core_ff;
   logic [3:0] dsp_ff;
   logic [WORD_W-1:0] last_word_ff;
   icd_state_t state_ff;
   icd_state_t nxt_state;
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic [OPC_W-1:0] res_opc_ff;
   icd_class_t res_cls_ff;
   logic [OPC_W-1:0] opc;
   logic [15:0] ops;
   icd_class_t cls;
   logic cond_true;
   logic take_first;
   logic take_second;
   logic discard;
   logic [1:0] extra;

   assign opc = FETCH_WORD_I[WORD_W-1:OPC_LO]; // RULE1
   assign ops = FETCH_WORD_I[OPC_LO-1:0];
   assign cls = opc_class(opc);

   // Branch condition is tested against the flags held here.
   always_comb begin
      case (opc[2:0])
         3'h0: cond_true = core_ff[FL_OV];
         3'h1: cond_true = core_ff[FL_C];
         3'h2: cond_true = core_ff[FL_Z];
         3'h3: cond_true = core_ff[FL_N];
         3'h4: cond_true = ~core_ff[FL_OV];
         3'h5: cond_true = ~core_ff[FL_C];
         3'h6: cond_true = ~core_ff[FL_Z];
         default: cond_true = ~core_ff[FL_N];
      endcase
      if (opc[3:0] == COND_ALWAYS) begin
         cond_true = 1'b1;
      end
   end

   always_comb begin
      case (cls)
         CLS_BRCOND: extra = cond_true ? EXTRA_BRANCH : 2'h0; // RULE4
         CLS_BRIND: extra = EXTRA_BRANCH; // RULE5
         CLS_RET: extra = EXTRA_RETURN; // RULE5
         CLS_TABLE: extra = EXTRA_TABLE; // RULE5
         CLS_MOVD: extra = EXTRA_MOVD;
         default: extra = 2'h0;
      endcase
   end

   // Sequencer: issue, second word fetch, nop slots and skip discards.
   // A word counts as taken only at an edge where the fetch side also moves on.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      take_first = 1'b0;
      take_second = 1'b0;
      discard = 1'b0;
      case (state_ff)
         ST_RUN, ST_SKIPCHK: begin
            if (FETCH_VALID_I && !STALL_O && state_ff == ST_SKIPCHK && SKIP_TAKEN_I) begin
               discard = 1'b1; // RULE6
               nxt_state = is_two_word(cls) ? ST_SKIP2 : ST_RUN; // RULE6
            end else if (FETCH_VALID_I && !STALL_O) begin
               take_first = 1'b1;
               if (is_two_word(cls)) begin
                  nxt_state = ST_WORD2; // RULE7
               end else if (extra != 2'h0) begin
                  nxt_state = ST_NOPS; // RULE22
                  nxt_cnt = extra;
               end else if (cls == CLS_SKIP) begin
                  nxt_state = ST_SKIPCHK;
               end else begin
                  nxt_state = ST_RUN;
               end
            end
         end
         ST_WORD2: begin
            if (FETCH_VALID_I && !STALL_O) begin
               take_second = 1'b1; // RULE2
               nxt_state = ST_RUN;
            end
         end
         ST_NOPS: begin
            nxt_cnt = cnt_ff - 2'h1;
            if (cnt_ff == 2'h1) begin
               nxt_state = ST_RUN;
            end
         end
         ST_SKIP2: begin
            if (FETCH_VALID_I && !STALL_O) begin
               discard = 1'b1; // RULE6
               nxt_state = ST_RUN;
            end
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         state_ff <= ST_RUN;
         cnt_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Pipeline control outputs; the fetch side holds its word while stalled.
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         STALL_O <= 1'b0;
         ISSUE_O <= 1'b0;
         SECOND_WORD_O <= 1'b0;
         NOP_SLOT_O <= 1'b0;
      end else begin
         STALL_O <= (nxt_state == ST_NOPS) || !ctrl_ff[0]; // RULE22
         ISSUE_O <= take_first;
         SECOND_WORD_O <= take_second;
         NOP_SLOT_O <= discard || (state_ff == ST_NOPS) ||
                       (take_first && cls == CLS_NOP); // RULE3 RULE22
      end
   end

   // Operand field decode, registered on issue of the first word.
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         OPCODE_O <= OPC_NOP;
         CLASS_O <= CLS_NOP;
         SIZE_O <= SZ_WORD;
         BASE_REG_O <= 4'h0;
         SRC_REG_O <= 4'h0;
         SRC_MODE_O <= 2'h0;
         DST_REG_O <= 4'h0;
         DST_MODE_O <= 2'h0;
         FILE_ADDR_O <= '0;
         DEST_IS_FILE_O <= 1'b0;
         BIT_POS_O <= 4'h0;
         POS_FROM_REG_O <= 1'b0;
         LITERAL_O <= '0;
         ACC_SEL_O <= 1'b0;
         AWB_MODE_O <= AWB_NONE;
         MAC_PREFETCH_O <= 9'h000;
         SHIFT_FROM_REG_O <= 1'b0;
         OPERAND_ERR_O <= 1'b0;
      end else if (take_first) begin
         OPCODE_O <= opc; // RULE1
         CLASS_O <= cls;
         BASE_REG_O <= ops[F_BASE+:4]; // RULE8
         SRC_REG_O <= ops[F_SREG+:4];
         SRC_MODE_O <= ops[F_SMODE+:2];
         DST_REG_O <= ops[F_DREG+:4];
         DST_MODE_O <= ops[F_DMODE+:2];
         SIZE_O <= (cls == CLS_MOVD) ? SZ_DOUBLE : opc[1:0]; // RULE21
         FILE_ADDR_O <= '0;
         DEST_IS_FILE_O <= 1'b0;
         BIT_POS_O <= ops[F_BIT_POSITION_FIELD+:4]; // RULE15
         POS_FROM_REG_O <= 1'b0;
         LITERAL_O <= '0;
         ACC_SEL_O <= ops[F_ACC];
         AWB_MODE_O <= AWB_NONE;
         MAC_PREFETCH_O <= 9'h000;
         SHIFT_FROM_REG_O <= 1'b0;
         OPERAND_ERR_O <= 1'b0;
         case (cls)
            CLS_FREG: begin
               SIZE_O <= {1'b0, opc[0]};
               FILE_ADDR_O <= ops[F_FADDR_W-1:0]; // RULE9
               DEST_IS_FILE_O <= ops[F_DSEL]; // RULE9
               DST_REG_O <= 4'h0;
            end
            CLS_LIT: begin
               SIZE_O <= {1'b0, opc[0]};
               BASE_REG_O <= ops[3:0];
               DST_MODE_O <= 2'h0;
               DST_REG_O <= ops[F_DSEL] ? 4'h0 : ops[3:0]; // RULE11
               if (opc[1]) begin
                  LITERAL_O <= LIT_W'($signed(ops[F_UNSIGNED_LITERAL_TEN+:10])); // RULE18
               end else begin
                  LITERAL_O <= LIT_W'(ops[F_UNSIGNED_LITERAL_TEN+:10]);
                  OPERAND_ERR_O <= (opc[3:0] & SIZE_MASK_LIT_BYTE) != 4'h0 &&
                                   ops[F_UNSIGNED_LITERAL_TEN+:10] > UNSIGNED_LITERAL_TEN_BYTE_MAX; // RULE16
               end
            end
            CLS_BIT, CLS_SKIP: begin
               SIZE_O <= SZ_WORD;
               if (opc[0]) begin
                  FILE_ADDR_O <= {ops[11:0], 1'b0}; // RULE10
                  DEST_IS_FILE_O <= 1'b1;
               end else begin
                  BASE_REG_O <= ops[F_BBASE+:4];
                  POS_FROM_REG_O <= ops[F_POSREG]; // RULE10
               end
            end
            CLS_MAC: begin
               SRC_REG_O <= MAC_W_BASE + {2'b00, ops[F_MX+:2]}; // RULE12
               BASE_REG_O <= MAC_W_BASE + {2'b00, ops[F_MY+:2]};
               MAC_PREFETCH_O <= ops[8:0];
               AWB_MODE_O <= ops[F_AWB+:2]; // RULE14
               DST_REG_O <= W13; // RULE14
            end
            CLS_DSP: begin
               SHIFT_FROM_REG_O <= ops[F_SHREG]; // RULE13
               BASE_REG_O <= ops[F_SLIT6+:4];
               LITERAL_O <= LIT_W'($signed(ops[F_SLIT6+:6])); // RULE13
            end
            CLS_BRCOND: LITERAL_O <= LIT_W'($signed(ops));
            CLS_CALL2, CLS_JUMP2: begin
               LITERAL_O <= {7'h00, ops[15:1], 1'b0}; // RULE17
               OPERAND_ERR_O <= ops[0]; // RULE17
            end
            CLS_LONG2: LITERAL_O <= LIT_W'(ops);
            default: ;
         endcase
      end else if (take_second) begin
         if (CLASS_O == CLS_LONG2) begin
            DST_REG_O <= FETCH_WORD_I[3:0];
         end else begin
            LITERAL_O[LIT_W-1:OPC_LO] <= FETCH_WORD_I[F_W2ADR_W-1:0]; // RULE2
         end
         OPERAND_ERR_O <= OPERAND_ERR_O || (opc != OPC_NOP) ||
                          FETCH_WORD_I[15:F_W2ADR_W] != '0; // RULE2
      end
   end

   // Class and opcode of the instruction whose result the datapath returns.
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         res_cls_ff <= CLS_NOP;
         res_opc_ff <= OPC_NOP;
         last_word_ff <= '0;
      end else if (take_first) begin
         res_cls_ff <= cls;
         res_opc_ff <= opc;
         last_word_ff <= FETCH_WORD_I;
      end
   end

   // Flags: a same-cycle result update overrides a software write in the flag bits that the update writes.
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         core_ff <= 5'h00;
         dsp_ff <= 4'h0;
      end else begin
         if (BUS_WR_I && BUS_ADDR_I == ADR_CORE_FLAGS) begin
            core_ff <= BUS_WDATA_I[4:0];
         end
         if (BUS_WR_I && BUS_ADDR_I == ADR_DSP_FLAGS) begin
            dsp_ff <= BUS_WDATA_I[3:0];
         end
         if (DP_RESULT_VALID_I) begin
            case (res_cls_ff)
               CLS_WORKING_REG_ZERO, CLS_FREG, CLS_LIT: begin
                  core_ff[4:1] <= DP_CORE_FLAGS_I[4:1]; // RULE19
                  // Carry-chain forms only clear zero, never set it.
                  core_ff[FL_Z] <= (res_cls_ff == CLS_WORKING_REG_ZERO && res_opc_ff[2]) ?
                                   (core_ff[FL_Z] & DP_CORE_FLAGS_I[FL_Z]) :
                                   DP_CORE_FLAGS_I[FL_Z]; // RULE19
               end
               CLS_BIT, CLS_SKIP: core_ff[FL_Z] <= DP_CORE_FLAGS_I[FL_Z]; // RULE19
               CLS_MAC, CLS_DSP: dsp_ff <= DP_DSP_FLAGS_I; // RULE20
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         ctrl_ff <= CTRL_RESET;
      end else if (BUS_WR_I && BUS_ADDR_I == ADR_CTRL) begin
         ctrl_ff <= BUS_WDATA_I[1:0];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         CORE_FLAGS_O <= 5'h00;
         DSP_FLAGS_O <= 4'h0;
      end else begin
         CORE_FLAGS_O <= core_ff;
         DSP_FLAGS_O <= dsp_ff;
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || !BUS_RD_I) begin
         BUS_RDATA_O <= '0;
      end else begin
         case (BUS_ADDR_I)
            ADR_CTRL: BUS_RDATA_O <= DATA_W'(ctrl_ff);
            ADR_CORE_FLAGS: BUS_RDATA_O <= DATA_W'(core_ff);
            ADR_DSP_FLAGS: BUS_RDATA_O <= DATA_W'(dsp_ff);
            ADR_LAST_WORD: BUS_RDATA_O <= DATA_W'(last_word_ff);
            default: BUS_RDATA_O <= '0;
         endcase
      end
   end
endmodule

// ### tb/icd_decoder_monitor.sv
`timescale 1ns/10ps
module icd_decoder_monitor import icd_pkg::*; #(
   parameter int DATA_W = 32
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic [WORD_W-1:0] FETCH_WORD_I,
   input wire logic SKIP_TAKEN_I,
   input wire logic BUS_RD_I,
   input wire logic [DATA_W-1:0] BUS_RDATA_O,
   input wire logic STALL_O,
   input wire logic ISSUE_O,
   input wire logic SECOND_WORD_O,
   input wire logic NOP_SLOT_O,
   input wire logic [OPC_W-1:0] OPCODE_O,
   input wire logic [3:0] CLASS_O,
   input wire logic [1:0] SIZE_O,
   input wire logic [LIT_W-1:0] LITERAL_O,
   input wire logic OPERAND_ERR_O
);
   logic [7:0] opc_in;
   assign opc_in = FETCH_WORD_I[23:16];
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);
   sequence s_one_slot;
      STALL_O ##1 (NOP_SLOT_O && !ISSUE_O);
   endsequence
   sequence s_two_slots;
      STALL_O ##1 (STALL_O && NOP_SLOT_O) ##1 (NOP_SLOT_O && !ISSUE_O);
   endsequence
   a_rdata_idle: assert property (!$past(BUS_RD_I) |-> BUS_RDATA_O == '0)
      else $error("read data not zero outside read answer");
   a_opcode_taken: assert property (ISSUE_O |-> OPCODE_O == $past(opc_in))
      else $error("opcode differs from fetched word");
   a_second_top: assert property (SECOND_WORD_O && $past(opc_in) != 8'h00 |-> OPERAND_ERR_O)
      else $error("second word with nonzero top byte not flagged");
   a_lone_nop: assert property (ISSUE_O && OPCODE_O == OPC_NOP |-> NOP_SLOT_O)
      else $error("lone second word not a no-operation");
   a_single_cycle: assert property (ISSUE_O && CLASS_O inside {CLS_WORKING_REG_ZERO, CLS_FREG, CLS_BIT,
      CLS_LIT} |=> !NOP_SLOT_O || ISSUE_O)
      else $error("extra slot after one-cycle instruction");
   a_branch_slot: assert property (ISSUE_O && CLASS_O inside {CLS_BRIND, CLS_TABLE, CLS_MOVD}
      |-> s_one_slot)
      else $error("branch, table or double move slot wrong");
   a_return_slots: assert property (ISSUE_O && CLASS_O == CLS_RET |-> s_two_slots)
      else $error("return slots wrong");
   a_skip_slot: assert property (ISSUE_O && CLASS_O == CLS_SKIP && SKIP_TAKEN_I
      |=> NOP_SLOT_O && !ISSUE_O)
      else $error("taken skip did not drop next word");
   a_two_word: assert property (ISSUE_O && CLASS_O inside {CLS_CALL2, CLS_JUMP2, CLS_LONG2}
      |=> SECOND_WORD_O)
      else $error("second word not absorbed next cycle");
   a_byte_range: assert property (ISSUE_O && CLASS_O == CLS_LIT && !OPCODE_O[1] &&
      SIZE_O == SZ_BYTE |-> OPERAND_ERR_O == (LITERAL_O[9:0] > UNSIGNED_LITERAL_TEN_BYTE_MAX))
      else $error("byte literal range check wrong");
   a_addr_even: assert property (ISSUE_O && CLASS_O inside {CLS_CALL2, CLS_JUMP2} |->
      OPERAND_ERR_O == $past(FETCH_WORD_I[0]) && !LITERAL_O[0])
      else $error("odd program address not flagged");
endmodule

bind icd_decoder icd_decoder_monitor #(.DATA_W(DATA_W)) u_monitor (
   .REF_CLK_I(REF_CLK_I),
   .RST_I(RST_I),
   .FETCH_WORD_I(FETCH_WORD_I),
   .SKIP_TAKEN_I(SKIP_TAKEN_I),
   .BUS_RD_I(BUS_RD_I),
   .BUS_RDATA_O(BUS_RDATA_O),
   .STALL_O(STALL_O),
   .ISSUE_O(ISSUE_O),
   .SECOND_WORD_O(SECOND_WORD_O),
   .NOP_SLOT_O(NOP_SLOT_O),
   .OPCODE_O(OPCODE_O),
   .CLASS_O(CLASS_O),
   .SIZE_O(SIZE_O),
   .LITERAL_O(LITERAL_O),
   .OPERAND_ERR_O(OPERAND_ERR_O)
);

// ### tb/icd_fetch_model.sv
`timescale 1ns/10ps
module icd_fetch_model import icd_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [3:0] len_i,
   input wire logic stall_i,
   output logic valid_o,
   output logic [WORD_W-1:0] word_o
);
   logic [WORD_W-1:0] mem [4];
   logic [3:0] pc_ff;
   logic [3:0] len_ff;
   logic [WORD_W-1:0] idle_ff;
   // The word moves on only at an edge that takes it: valid and no stall.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_ff <= 4'h0;
         len_ff <= 4'h0;
      end else if (start_i) begin
         pc_ff <= 4'h0;
         len_ff <= len_i;
      end else if (valid_o && !stall_i) begin
         pc_ff <= pc_ff + 4'h1;
      end
   end
   // Between programs the word lines toggle so a stale word is never seen.
   always_ff @(posedge clk_i) begin
      idle_ff <= rst_i ? 24'h5A_C3A5 : ~idle_ff;
   end
   assign valid_o = pc_ff < len_ff;
   assign word_o = valid_o ? mem[pc_ff[1:0]] : idle_ff;
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench import icd_pkg::*;;
   localparam logic [23:0] WR = 24'h40_A953;
   logic clk, rst, start, skp, dpv, wr, rd, valid, stall, issue, sec, nop, err, acc, dfile;
   logic pfr, sfr;
   logic [3:0] plen, dpd, cls, base, sreg, dreg, bpos, dspf;
   logic [4:0] dpc, coref;
   logic [7:0] addr, opc;
   logic [31:0] wdata, rdata, tr;
   logic [23:0] word;
   logic [1:0] size, smode, dmode, acc_writeback_dest;
   logic [12:0] faddr;
   logic [22:0] lit;
   logic [8:0] mpf;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   icd_fetch_model i_fetch (.clk_i(clk), .rst_i(rst), .start_i(start), .len_i(plen),
      .stall_i(stall), .valid_o(valid), .word_o(word));
   icd_decoder i_dut (.REF_CLK_I(clk), .RST_I(rst), .FETCH_VALID_I(valid), .FETCH_WORD_I(word),
      .SKIP_TAKEN_I(skp), .DP_RESULT_VALID_I(dpv), .DP_CORE_FLAGS_I(dpc),
      .DP_DSP_FLAGS_I(dpd), .BUS_ADDR_I(addr), .BUS_WDATA_I(wdata), .BUS_WR_I(wr),
      .BUS_RD_I(rd), .BUS_RDATA_O(rdata), .STALL_O(stall), .ISSUE_O(issue),
      .SECOND_WORD_O(sec), .NOP_SLOT_O(nop), .OPCODE_O(opc), .CLASS_O(cls), .SIZE_O(size),
      .BASE_REG_O(base), .SRC_REG_O(sreg), .SRC_MODE_O(smode), .DST_REG_O(dreg),
      .DST_MODE_O(dmode), .FILE_ADDR_O(faddr), .DEST_IS_FILE_O(dfile), .BIT_POS_O(bpos),
      .POS_FROM_REG_O(pfr), .LITERAL_O(lit), .ACC_SEL_O(acc), .AWB_MODE_O(acc_writeback_dest),
      .MAC_PREFETCH_O(mpf), .SHIFT_FROM_REG_O(sfr), .OPERAND_ERR_O(err),
      .CORE_FLAGS_O(coref), .DSP_FLAGS_O(dspf));
   always #50 clk = ~clk;
   // One hex digit per busy cycle: issue 4, second word 2, no-operation slot 1.
   always @(posedge clk) begin
      if (start) tr <= '0;
      else if (issue | sec | nop) tr <= {tr[27:0], 1'b0, issue, sec, nop};
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run;
      end
   end
   task complete_run;
      $display("Checks run %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task run(input logic [23:0] w0, w1, w2, w3, input logic [3:0] n, input logic s,
      input logic [31:0] e);
      i_fetch.mem[0] = w0;
      i_fetch.mem[1] = w1;
      i_fetch.mem[2] = w2;
      i_fetch.mem[3] = w3;
      @(posedge clk);
      skp <= s;
      plen <= n;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      for (int i = 0; i < 20 && valid; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      skp <= 1'b0;
      chk(tr, e);
   endtask
   task t_regs;
      rchk(ADR_CTRL, 32'h0000_0001);
      rchk(ADR_CORE_FLAGS, 32'h0000_0000);
      rchk(ADR_DSP_FLAGS, 32'h0000_0000);
      rchk(ADR_LAST_WORD, 32'h0000_0000);
      bus_wr(8'h10, 32'hFFFF_FFFF);
      rchk(8'h10, 32'h0000_0000);
      bus_wr(ADR_LAST_WORD, 32'h00AB_CDEF);
      rchk(ADR_LAST_WORD, 32'h0000_0000);
   endtask
   task t_timing;
      run(WR, WR, 0, 0, 2, 0, 32'h44);
      run(24'h06_0000, WR, 0, 0, 2, 0, 32'h4114);
      run(24'h07_0000, WR, 0, 0, 2, 0, 32'h4114);
      run(24'h01_0000, WR, 0, 0, 2, 0, 32'h414);
      run(24'h90_0000, WR, 0, 0, 2, 0, 32'h414);
      run(24'h3F_0000, WR, 0, 0, 2, 0, 32'h414);
      run(24'hA0_0000, WR, 0, 0, 2, 0, 32'h414);
      run(24'h04_1234, 24'h00_0056, WR, 0, 3, 0, 32'h424);
      run(24'h02_1234, 24'h00_0056, WR, 0, 3, 0, 32'h424);
      run(24'h05_1234, 24'h00_0056, WR, 0, 3, 0, 32'h424);
      run(24'h00_0123, WR, 0, 0, 2, 0, 32'h54);
      run(24'h80_0000, WR, WR, 0, 3, 1, 32'h414);
      run(24'h80_0000, 24'h04_1234, 24'h00_0056, WR, 4, 1, 32'h4114);
      run(24'h80_0000, WR, 0, 0, 2, 0, 32'h44);
   endtask
   task t_fields;
      run(WR, 0, 0, 0, 1, 0, 32'h4);
      chk(opc, 8'h40);
      chk(cls, CLS_WORKING_REG_ZERO);
      chk(base, 4'hA);
      chk({dmode, dreg, smode, sreg}, 12'h953);
      chk(size, SZ_WORD);
      rchk(ADR_LAST_WORD, 32'h0040_A953);
      run(24'h60_9ABC, 0, 0, 0, 1, 0, 32'h4);
      chk({dfile, faddr}, 14'h3ABC);
      run(24'h70_F000, 0, 0, 0, 1, 0, 32'h4);
      chk({pfr, bpos}, 5'h0F);
      run(24'h70_0080, 0, 0, 0, 1, 0, 32'h4);
      chk(pfr, 1'b1);
      run(24'hC0_C1A5, 0, 0, 0, 1, 0, 32'h4);
      chk({dreg, acc, acc_writeback_dest, mpf}, 16'hDDA5);
      run(24'hB0_4000, 0, 0, 0, 1, 0, 32'h4);
      chk({acc, sfr}, 2'h1);
      run(24'h51_0FF0, 0, 0, 0, 1, 0, 32'h4);
      chk({size, err, lit}, {SZ_BYTE, 1'b0, 23'h00_00FF});
      run(24'h51_1000, 0, 0, 0, 1, 0, 32'h4);
      chk(err, 1'b1);
      run(24'h50_3FF0, 0, 0, 0, 1, 0, 32'h4);
      chk({err, lit}, 24'h00_03FF);
      run(24'h52_2000, 0, 0, 0, 1, 0, 32'h4);
      chk(lit, 23'h7F_FE00);
      run(24'h50_8000, 0, 0, 0, 1, 0, 32'h4);
      chk(dreg, 4'h0);
      run(24'h04_1234, 24'h00_0056, 0, 0, 2, 0, 32'h42);
      chk({err, lit}, 24'h56_1234);
      run(24'h04_1235, 24'h00_0056, 0, 0, 2, 0, 32'h42);
      chk(err, 1'b1);
      run(24'h04_1234, 24'h01_0056, 0, 0, 2, 0, 32'h42);
      chk(err, 1'b1);
   endtask
   task dp_pulse(input logic [4:0] c, input logic [3:0] d);
      @(posedge clk);
      dpc <= c;
      dpd <= d;
      dpv <= 1'b1;
      @(posedge clk);
      dpv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task t_flags;
      bus_wr(ADR_CORE_FLAGS, 32'h0000_0015);
      rchk(ADR_CORE_FLAGS, 32'h0000_0015);
      chk(coref, 5'h15);
      run(24'h30_0000, WR, 0, 0, 2, 0, 32'h44);
      run(24'h31_0000, WR, 0, 0, 2, 0, 32'h414);
      run(24'hB0_0000, 0, 0, 0, 1, 0, 32'h4);
      dp_pulse(5'h0B, 4'h5);
      chk({coref, dspf}, 9'h155);
      rchk(ADR_DSP_FLAGS, 32'h0000_0005);
      run(WR, 0, 0, 0, 1, 0, 32'h4);
      dp_pulse(5'h0A, 4'h0);
      run(24'h44_0000, 0, 0, 0, 1, 0, 32'h4);
      dp_pulse(5'h0B, 4'h0);
      chk({coref, dspf}, 9'h0A5);
   endtask
   task t_enable;
      bus_wr(ADR_CTRL, 32'h0000_0000);
      run(WR, 0, 0, 0, 1, 0, 32'h0);
      chk(stall, 1'b1);
      bus_wr(ADR_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      chk(tr, 32'h4);
   endtask
   initial begin
      {clk, start, skp, dpv, wr, rd, plen, dpd, dpc, addr, wdata} = '0;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_timing;
      t_fields;
      t_flags;
      t_enable;
      complete_run;
   end
endmodule
